// ### rtl/acbi_pkg.sv
package acbi_pkg;
  localparam int ACBI_DATA_WIDTH = 8;
  localparam int ACBI_ADDR_WIDTH = 6;
  localparam int ACBI_REG_COUNT = 64;
  localparam logic [7:0] ACBI_REG_RESET = 8'h00;
  localparam logic [7:0] ACBI_DATA_IDLE = 8'h00;
  localparam logic [1:0] ACBI_SYNC_ONES = 2'h3;
endpackage

// ### rtl/acbi_reg_mem.sv
`timescale 1ns/1ns
`default_nettype none
module acbi_reg_mem
  import acbi_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [acbi_pkg::ACBI_ADDR_WIDTH-1:0] wr_addr_in,
  input wire logic [acbi_pkg::ACBI_DATA_WIDTH-1:0] wr_data_in,
  // read port
  input wire logic [acbi_pkg::ACBI_ADDR_WIDTH-1:0] rd_addr_in,
  output logic [acbi_pkg::ACBI_DATA_WIDTH-1:0] rd_data_out
);
  import acbi_pkg::*;
  logic [ACBI_DATA_WIDTH-1:0] mem [ACBI_REG_COUNT];
  // registered read data; a write and a read to the same entry return the old value
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rd_data_out <= ACBI_REG_RESET;
      for (int i = 0; i < ACBI_REG_COUNT; i++) begin
        mem[i] <= ACBI_REG_RESET;
      end
    end else begin
      rd_data_out <= mem[rd_addr_in];
      if (wr_en_in) begin
        mem[wr_addr_in] <= wr_data_in;
      end
    end
  end
endmodule // acbi_reg_mem
`default_nettype wire

// ### rtl/acbi_host_port.sv
// Operation
// [RULE_01] The host data bus is eight bits wide and bidirectional, bit 0 least and bit 7 most significant.
// [RULE_02] While chip select is low, only the asserted write or read strobe sets the transfer direction.
// [RULE_03] With chip select high the bus is not driven and strobes are ignored.
// [RULE_04] A write is latched into the selected register on the rising edge of the write strobe. The code writes it at the second clock edge after it.
// [RULE_05] A read drives the selected register onto the bus from the falling edge of the read strobe. The code drives from the second clock edge after it.
// [RULE_06] The host presents a six-bit register select with every access.
// [RULE_07] The host never asserts both strobes together and holds the select stable while a strobe is low.
`timescale 1ns/1ns
`default_nettype none
module acbi_host_port
  import acbi_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // host strobes and select
  input wire logic chip_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic [acbi_pkg::ACBI_ADDR_WIDTH-1:0] register_select_in,
  // host data bus, split into three signals
  input wire logic [acbi_pkg::ACBI_DATA_WIDTH-1:0] host_data_bus_in,
  output logic [acbi_pkg::ACBI_DATA_WIDTH-1:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  // write event seen by the register logic
  output logic write_pulse_out
);
  import acbi_pkg::*;

  typedef enum logic [2:0] {
    ACBI_IDLE = 3'h1,
    ACBI_WRITE = 3'h2,
    ACBI_READ = 3'h4
  } acbi_state_type;

  typedef struct packed {
    acbi_state_type state;
    logic [ACBI_DATA_WIDTH-1:0] wr_data;
    logic [ACBI_ADDR_WIDTH-1:0] wr_addr;
    logic [ACBI_DATA_WIDTH-1:0] dout;
    logic oe;
    logic wr_pulse;
    logic read_fresh;
  } acbi_regs_type;

  acbi_regs_type r;
  acbi_regs_type next_r;
  logic [ACBI_DATA_WIDTH-1:0] mem_rd_data;
  logic wr_active;
  logic rd_active;

  // strobes only count while selected; both low together is a host fault, write wins
  assign wr_active = !chip_select_n_in && !write_strobe_n_in; // [RULE_02]
  assign rd_active = !chip_select_n_in && !read_strobe_n_in && write_strobe_n_in; // [RULE_02] [RULE_03]

  // a strobe seen low at one edge moves the state there; drive and read data follow one edge later
  always_comb begin
    next_r = r;
    next_r.wr_pulse = 1'b0;
    next_r.read_fresh = 1'b0;
    unique case (r.state)
      ACBI_IDLE: begin
        next_r.oe = 1'b0;
        if (wr_active) begin
          // take data and select at once, a strobe may be low for a single edge
          next_r.wr_data = host_data_bus_in;
          next_r.wr_addr = register_select_in; // [RULE_06]
          next_r.state = ACBI_WRITE;
        end else if (rd_active) begin
          next_r.state = ACBI_READ; // [RULE_05]
          next_r.read_fresh = 1'b1;
        end
      end
      ACBI_WRITE: begin
        if (wr_active) begin
          // track the bus only while the strobe is low; at the release edge the host may have moved on
          next_r.wr_data = host_data_bus_in;
          next_r.wr_addr = register_select_in; // [RULE_06]
        end else begin
          next_r.wr_pulse = 1'b1; // [RULE_04]
          next_r.state = ACBI_IDLE;
        end
      end
      ACBI_READ: begin
        next_r.oe = rd_active; // [RULE_03] [RULE_05]
        next_r.dout = mem_rd_data; // [RULE_01]
        if (!rd_active) begin
          next_r.oe = 1'b0;
          next_r.state = ACBI_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      r.state <= ACBI_IDLE;
      r.wr_data <= ACBI_DATA_IDLE;
      r.wr_addr <= '0;
      r.dout <= ACBI_DATA_IDLE;
      r.oe <= 1'b0;
      r.wr_pulse <= 1'b0;
      r.read_fresh <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  acbi_reg_mem u_mem (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .wr_en_in(r.wr_pulse),
    .wr_addr_in(r.wr_addr),
    .wr_data_in(r.wr_data),
    .rd_addr_in(register_select_in),
    .rd_data_out(mem_rd_data)
  );

  assign host_data_bus_out = r.dout;
  // drop the drive at once when the host lets go, to avoid bus contention
  assign host_data_bus_oe_out = r.oe && rd_active; // [RULE_03]
  assign write_pulse_out = r.wr_pulse;

  // deselect and direction
  chk_deselect_no_drive: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_03]
    chip_select_n_in |-> !host_data_bus_oe_out)
    else $error("bus driven while deselected");

  chk_no_drive_on_write: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_02]
    !read_strobe_n_in == 1'b0 |-> !host_data_bus_oe_out)
    else $error("bus driven without read strobe");

  chk_no_drive_writing: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_02]
    !write_strobe_n_in |-> !host_data_bus_oe_out)
    else $error("bus driven while write strobe low");

  chk_drive_needs_strobe: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_05]
    host_data_bus_oe_out |-> (!chip_select_n_in && !read_strobe_n_in && write_strobe_n_in))
    else $error("bus driven outside a read");

  chk_deselect_stays_idle: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_03]
    (r.state == ACBI_IDLE && chip_select_n_in) |=> r.state == ACBI_IDLE)
    else $error("access started while deselected");

  chk_idle_no_drive: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_03]
    (r.state == ACBI_IDLE) |-> !r.oe)
    else $error("drive enable held in idle");

  chk_state_onehot: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_02]
    $onehot(r.state))
    else $error("access state not one-hot");

  // write path
  chk_write_on_release: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_04]
    (r.state == ACBI_WRITE && !wr_active) |=> write_pulse_out)
    else $error("write not taken at strobe release");

  chk_write_only_release: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_04]
    write_pulse_out |-> $past(r.state) == ACBI_WRITE)
    else $error("write pulse without write strobe");

  chk_write_data_kept: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_01]
    (r.state == ACBI_WRITE && !wr_active) |=> r.wr_data == $past(host_data_bus_in, 2))
    else $error("write data not the last sampled value");

  chk_write_select_kept: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_04]
    (r.state == ACBI_WRITE && !wr_active) |=> r.wr_addr == $past(register_select_in, 2))
    else $error("write select not the last sampled value");

  chk_write_enters: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_04]
    (r.state == ACBI_IDLE && wr_active) |=> r.state == ACBI_WRITE)
    else $error("write strobe not taken");

  chk_write_holds_state: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_04]
    (r.state == ACBI_WRITE && wr_active) |=> (r.state == ACBI_WRITE && !write_pulse_out))
    else $error("write committed while strobe still low");

  chk_pulse_single: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_04]
    write_pulse_out |=> !write_pulse_out)
    else $error("write pulse longer than one cycle");

  chk_pulse_from_release: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_04]
    write_pulse_out |-> !$past(wr_active))
    else $error("write pulse without strobe release");

  chk_no_write_in_read: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_02]
    (r.state == ACBI_READ) |=> !write_pulse_out)
    else $error("write pulse during read");

  // read path
  chk_read_drives_soon: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_05]
    (r.state == ACBI_IDLE && rd_active) ##1 rd_active ##1 rd_active |-> host_data_bus_oe_out)
    else $error("read not driven two cycles after strobe");

  chk_read_data_reg: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_05]
    (r.state == ACBI_READ && rd_active) |=> host_data_bus_out == $past(mem_rd_data))
    else $error("read data does not follow selected register");

  chk_read_enters: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_05]
    (r.state == ACBI_IDLE && rd_active) |=> (r.state == ACBI_READ && r.read_fresh))
    else $error("read strobe not taken");

  chk_read_fresh_entry: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_05]
    r.read_fresh |-> (r.state == ACBI_READ && !r.oe))
    else $error("drive enabled before read data settled");

  chk_drive_stays: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_05]
    (r.state == ACBI_READ && rd_active) |=> (host_data_bus_oe_out || !rd_active))
    else $error("drive dropped while read strobe low");

  chk_release_stops_read: assert property (@(posedge core_clk_in) disable iff (reset_in) // [RULE_05]
    (r.state == ACBI_READ && !rd_active) |=> (r.state == ACBI_IDLE && !r.oe))
    else $error("read not ended at strobe release");

  // main scenarios
  cov_write: cover property (@(posedge core_clk_in) disable iff (reset_in) write_pulse_out);
  cov_read: cover property (@(posedge core_clk_in) disable iff (reset_in) host_data_bus_oe_out);
  cov_back_to_back: cover property (@(posedge core_clk_in) disable iff (reset_in)
    write_pulse_out ##[1:8] host_data_bus_oe_out);
  cov_deselected_strobe: cover property (@(posedge core_clk_in) disable iff (reset_in)
    chip_select_n_in && !(write_strobe_n_in && read_strobe_n_in));
endmodule // acbi_host_port
`default_nettype wire

// ### testbench/acbi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module acbi_host_model (
  // clock and device side
  input wire logic clk_in,
  input wire logic oe_in,
  input wire logic [7:0] dev_data_in,
  // host strobes, select and bus
  output logic cs_n_out,
  output logic wr_n_out,
  output logic rd_n_out,
  output logic [5:0] sel_out,
  output logic [7:0] bus_out
);
  logic [7:0] drv = 8'h5A;
  initial begin
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    sel_out = 6'h00;
  end
  // released bus shows the inverse of the last byte, so stale data never matches
  assign bus_out = oe_in ? dev_data_in : drv;
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic cs_off);
    @(posedge clk_in) #1;
    cs_n_out = cs_off;
    wr_n_out = 1'b0;
    sel_out = a;
    drv = d;
    repeat (3) @(posedge clk_in);
    #1 wr_n_out = 1'b1;
    cs_n_out = 1'b1;
    drv = ~d;
  endtask
  task automatic rd(input logic [5:0] a, input logic cs_off, output logic [7:0] d, output logic ok);
    @(posedge clk_in) #1;
    cs_n_out = cs_off;
    rd_n_out = 1'b0;
    sel_out = a;
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk_in) #1 ok = (oe_in === 1'b1);
    end
    @(posedge clk_in) #1 d = bus_out;
    rd_n_out = 1'b1;
    cs_n_out = 1'b1;
  endtask
endmodule // acbi_host_model
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import acbi_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cs_n, wr_n, rd_n, oe, pulse, ok;
  logic [5:0] sel;
  logic [7:0] bus, dout, got, seed;
  logic [7:0] exp_mem [64];
  int fails = 0;
  int cmp_count = 0;
  int pulses = 0;
  logic hung = 1'b0;
  always #5 core_clk_in = ~core_clk_in;
  acbi_host_model h (.clk_in(core_clk_in), .oe_in(oe), .dev_data_in(dout), .cs_n_out(cs_n),
    .wr_n_out(wr_n), .rd_n_out(rd_n), .sel_out(sel), .bus_out(bus));
  acbi_host_port DUT (.core_clk_in(core_clk_in), .reset_in(reset_in), .chip_select_n_in(cs_n),
    .write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n), .register_select_in(sel),
    .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe_out(oe), .write_pulse_out(pulse));
  // sample between edges, away from the edge that launches the outputs
  always @(negedge core_clk_in) begin
    if (pulse === 1'b1) pulses++;
    if (cs_n === 1'b1 && oe !== 1'b0) check(8'h01, 8'h00, "drive while deselected");
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [7:0] g, input logic [7:0] w, input string m);
    cmp_count++;
    if (g !== w) begin
      fails++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, w);
    end
  endtask
  task automatic access(input logic [5:0] a, input logic [7:0] d, input logic cs_off);
    int p0;
    p0 = pulses;
    h.wr(a, d, cs_off);
    repeat (4) @(posedge core_clk_in);
    check(8'(pulses - p0), {7'h00, ~cs_off}, "write pulse count");
    if (!cs_off) exp_mem[a] = d;
    if (cs_off) begin
      h.rd(a, 1'b1, got, ok);
      check({7'h00, ok}, 8'h00, "drive on deselected read");
    end
    h.rd(a, 1'b0, got, ok);
    if (!ok) hung = 1'b1;
    check({7'h00, ok}, 8'h01, "no read drive");
    check(got, exp_mem[a], "read data");
    #1 check({7'h00, oe}, 8'h00, "drive after release");
    repeat (2) @(posedge core_clk_in);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    seed = 8'h21;
    foreach (exp_mem[i]) exp_mem[i] = 8'h00;
    repeat (16) @(posedge core_clk_in);
    #1 reset_in = 1'b0;
    access(6'h3F, 8'hA5, 1'b1);
    access(6'h00, 8'h01, 1'b0);
    access(6'h3F, 8'h80, 1'b0);
    for (int i = 0; i < 24 && !hung; i++) begin
      seed = lfsr(seed);
      access(seed[7:2], lfsr(seed), 1'b0);
    end
    conclude();
  end
endmodule // tb
`default_nettype wire
